// *** hw/qsp_defines.svh ***
// Register offsets, field positions and reset values of the QoS scheduler.
`ifndef QSP_DEFINES_SVH
`define QSP_DEFINES_SVH

`define QSP_ADDR_W 8
`define QSP_STAMP_W 8

`define QSP_REG_CTRL 8'h00
`define QSP_REG_WEIGHT 8'h04
`define QSP_REG_MAP 8'h08
`define QSP_REG_PORT_CMD 8'h0c
`define QSP_REG_PORT_CFG 8'h10
`define QSP_REG_LEVEL 8'h14
`define QSP_REG_SCHED 8'h18
`define QSP_REG_SENT_LO 8'h1c
`define QSP_REG_SENT_HI 8'h20

`define QSP_CTRL_MODE_LSB 0
`define QSP_PCMD_MASK_LSB 16
`define QSP_PCFG_EN_BIT 3
`define QSP_SCHED_CREDIT_LSB 8
`define QSP_SCHED_OUT_BIT 16
`define QSP_SCHED_AVAIL_LSB 20

`define QSP_WEIGHT_RST 32'h08040201
`define QSP_MAP_RST 16'hfa50
`define QSP_PORT_CFG_RST 4'h0

`endif

// *** hw/qsp_pkg.sv ***
// Types shared by the QoS scheduler modules.
package qsp_pkg;

  typedef enum logic [1:0] {
    MODE_ARRIVAL = 2'b00,
    MODE_STRICT = 2'b01,
    MODE_WRR = 2'b10
  } qsp_mode_e;

  typedef enum logic [1:0] {
    LOWEST_QUEUE = 2'b00,
    SECOND_LOW_QUEUE = 2'b01,
    SECOND_HIGH_QUEUE = 2'b10,
    HIGHEST_QUEUE = 2'b11
  } qsp_queue_e;

  typedef logic [1:0] qsp_queue_t;

endpackage

// *** hw/qsp_stream_if.sv ***
// Valid/ready stream carrier between the scheduler and its queue buffers.
interface qsp_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** hw/qsp_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides and a fill level.
module qsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input wire logic clk_i,
  input wire logic rst_i,
  qsp_stream_if.snk push,
  qsp_stream_if.src pop,
  output logic [$clog2(DEPTH):0] level_o
);
  import qsp_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } qsp_fifo_state_s;

  qsp_fifo_state_s s_reg;
  qsp_fifo_state_s s_next;
  logic do_push;
  logic do_pop;

  // Full and empty come straight from the count so neither side is ever misled.
  assign push.ready = (s_reg.cnt != (PW + 1)'(DEPTH));
  assign pop.valid = (s_reg.cnt != '0);
  assign pop.data = s_reg.mem[s_reg.rd];
  assign level_o = s_reg.cnt;
  assign do_push = push.valid && push.ready;
  assign do_pop = pop.valid && pop.ready;

  always_comb
  begin
    s_next = s_reg;
    if (do_push)
    begin
      s_next.mem[s_reg.wr] = push.data;
      s_next.wr = (s_reg.wr == PW'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
    end
    if (do_pop)
    begin
      s_next.rd = (s_reg.rd == PW'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

// *** hw/qsp_scheduler.sv ***
// Egress QoS classifier, four transmit queues and the queue scheduler.
`include "qsp_defines.svh"

// What this block does
// R1 - Every accepted packet goes into exactly one of four ranked transmit queues.
// R2 - In arrival-order mode packets leave in the order they came, whatever their queue.
// R3 - In strict-priority mode no queue is served while a higher queue holds a packet.
// R4 - After reset the mode is weighted round robin with weights 8, 4, 2 and 1.
// R5 - Each weight is programmable and sets how many packets a queue sends per turn.
// R6 - A tagged packet picks its queue by looking its 3-bit priority up in the map table.
// R7 - An untagged packet takes its port's static priority and goes through the same table.
// R8 - The map table is programmable per priority and resets to pairs 0-1,2-3,4-5,6-7 upward.
// R9 - Software may change any priority's queue at run time.
// R10 - Static port priority is disabled or 0 to 7, written to a port set or to all ports.
// R11 - Round robin skips an empty queue and restarts at the highest with fresh credit.
// R12 - Untagged packets of a port whose static priority is disabled go to the lowest queue.
module qsp_scheduler #(
  parameter int NUM_PORTS = 8,
  parameter int PORT_W = 3,
  parameter int DATA_W = 16,
  parameter int DEPTH = 16
)(
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [`QSP_ADDR_W-1:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  input wire logic PKT_VALID_I,
  output logic PKT_READY_O,
  input wire logic PKT_TAGGED_I,
  input wire logic [2:0] PKT_PCP_I,
  input wire logic [PORT_W-1:0] PKT_PORT_I,
  input wire logic [DATA_W-1:0] PKT_DATA_I,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  output qsp_pkg::qsp_queue_t TX_QUEUE_O,
  output logic [DATA_W-1:0] TX_DATA_O
);
  import qsp_pkg::*;

  localparam int SW = `QSP_STAMP_W;
  localparam int ENT_W = SW + DATA_W;
  localparam int LVL_W = $clog2(DEPTH) + 1;

  typedef struct packed {
    qsp_mode_e mode;
    logic [3:0][7:0] weight;
    logic [7:0][1:0] map;
    logic [NUM_PORTS-1:0][3:0] port_cfg;
    logic [SW-1:0] stamp;
    qsp_queue_t cur;
    logic [7:0] credit;
    logic [3:0][15:0] sent;
    logic out_valid;
    qsp_queue_t out_queue;
    logic [DATA_W-1:0] out_data;
    logic [31:0] rdata;
  } qsp_state_s;

  // R4 reset weights
  localparam qsp_state_s STATE_RST = '{
    mode: MODE_WRR,
    weight: `QSP_WEIGHT_RST,
    map: `QSP_MAP_RST,
    port_cfg: {NUM_PORTS{`QSP_PORT_CFG_RST}},
    default: '0
  };

  qsp_state_s s_reg;
  qsp_state_s s_next;

  logic [3:0] push_valid;
  logic [3:0] push_ready;
  logic [3:0] pop_valid;
  logic [3:0] pop_ready;
  logic [3:0][ENT_W-1:0] pop_data;
  logic [3:0][LVL_W-1:0] level;
  logic map_used;
  logic [2:0] prio_eff;
  qsp_queue_t cls;
  logic found;
  logic fresh;
  logic take;
  qsp_queue_t sel;
  qsp_queue_t cand;

  // Stamps wrap; with at most four full queues the distance stays below half the range.
  function automatic logic is_older(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic [SW-1:0] d;
    d = a - b;
    return d[SW-1];
  endfunction

  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_queue
    qsp_stream_if #(.WIDTH(ENT_W)) push_if ();
    qsp_stream_if #(.WIDTH(ENT_W)) pop_if ();

    // R1 one queue only
    assign push_valid[g] = PKT_VALID_I && (cls == qsp_queue_t'(g));
    assign push_if.valid = push_valid[g];
    assign push_if.data = {s_reg.stamp, PKT_DATA_I};
    assign push_ready[g] = push_if.ready;
    assign pop_valid[g] = pop_if.valid;
    assign pop_data[g] = pop_if.data;
    assign pop_ready[g] = take && (sel == qsp_queue_t'(g));
    assign pop_if.ready = pop_ready[g];

    qsp_fifo #(
      .WIDTH(ENT_W),
      .DEPTH(DEPTH)
    ) u_fifo (
      .clk_i(CORE_CLK_I),
      .rst_i(SYS_RST_I),
      .push(push_if),
      .pop(pop_if),
      .level_o(level[g])
    );
  end

  // R7 static port priority
  assign map_used = PKT_TAGGED_I || s_reg.port_cfg[PKT_PORT_I][`QSP_PCFG_EN_BIT];
  assign prio_eff = PKT_TAGGED_I ? PKT_PCP_I : s_reg.port_cfg[PKT_PORT_I][2:0];
  // R6 tag lookup, R12 disabled port to lowest
  assign cls = map_used ? s_reg.map[prio_eff] : qsp_queue_t'(LOWEST_QUEUE);
  // A full target queue stalls the ingress path instead of dropping.
  assign PKT_READY_O = push_ready[cls];

  assign take = found && (!s_reg.out_valid || TX_READY_I);

  always_comb
  begin
    found = 1'b0;
    fresh = 1'b0;
    sel = '0;
    cand = '0;
    unique case (s_reg.mode)
      MODE_ARRIVAL:
      begin
        // R2 oldest head first
        for (int i = 0; i < 4; i++)
        begin
          if (pop_valid[i] && (!found ||
              is_older(pop_data[i][ENT_W-1 -: SW], pop_data[sel][ENT_W-1 -: SW])))
          begin
            found = 1'b1;
            sel = qsp_queue_t'(i);
          end
        end
      end
      MODE_STRICT:
      begin
        // R3 highest nonempty wins
        for (int i = 0; i < 4; i++)
        begin
          if (pop_valid[i])
          begin
            found = 1'b1;
            sel = qsp_queue_t'(i);
          end
        end
      end
      MODE_WRR:
      begin
        // R5 weight limits a turn, R11 skip empty and wrap with fresh credit
        for (int k = 0; k <= 4; k++)
        begin
          cand = s_reg.cur - 2'(k);
          if (!found && pop_valid[cand] &&
              (k != 0 || s_reg.credit < s_reg.weight[s_reg.cur]))
          begin
            found = 1'b1;
            sel = cand;
            fresh = (k != 0);
          end
        end
      end
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = '0;
    if (PKT_VALID_I && PKT_READY_O)
    begin
      s_next.stamp = s_reg.stamp + 1'b1;
    end
    if (s_reg.out_valid && TX_READY_I)
    begin
      s_next.out_valid = 1'b0;
    end
    if (take)
    begin
      s_next.out_valid = 1'b1;
      s_next.out_data = pop_data[sel][DATA_W-1:0];
      s_next.out_queue = sel;
      s_next.sent[sel] = s_reg.sent[sel] + 16'h0001;
      // R5, R11 round robin bookkeeping
      if (s_reg.mode == MODE_WRR)
      begin
        s_next.cur = sel;
        s_next.credit = fresh ? 8'h01 : s_reg.credit + 8'h01;
      end
    end
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        `QSP_REG_CTRL:
        begin
          // Code 3 has no mode; it falls back to round robin so the state stays legal.
          if (REG_WDATA_I[`QSP_CTRL_MODE_LSB +: 2] == 2'h3)
          begin
            s_next.mode = MODE_WRR;
          end
          else
          begin
            s_next.mode = qsp_mode_e'(REG_WDATA_I[`QSP_CTRL_MODE_LSB +: 2]);
          end
          s_next.credit = '0;
        end
        // R5 weights programmable
        `QSP_REG_WEIGHT:
        begin
          s_next.weight = REG_WDATA_I;
        end
        // R8 map programmable, R9 at run time
        `QSP_REG_MAP:
        begin
          s_next.map = REG_WDATA_I[15:0];
        end
        // R10 set of ports or all
        `QSP_REG_PORT_CMD:
        begin
          for (int p = 0; p < NUM_PORTS; p++)
          begin
            if (REG_WDATA_I[`QSP_PCMD_MASK_LSB + p] ||
                REG_WDATA_I[31:`QSP_PCMD_MASK_LSB] == 16'h0000)
            begin
              s_next.port_cfg[p] = REG_WDATA_I[3:0];
            end
          end
        end
        `QSP_REG_SENT_LO:
        begin
          s_next.sent = '0;
        end
        default:
        begin
        end
      endcase
    end
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `QSP_REG_CTRL:
        begin
          s_next.rdata[`QSP_CTRL_MODE_LSB +: 2] = s_reg.mode;
        end
        `QSP_REG_WEIGHT:
        begin
          s_next.rdata = s_reg.weight;
        end
        `QSP_REG_MAP:
        begin
          s_next.rdata[15:0] = s_reg.map;
        end
        `QSP_REG_PORT_CFG:
        begin
          for (int p = 0; p < NUM_PORTS && p < 8; p++)
          begin
            s_next.rdata[4*p +: 4] = s_reg.port_cfg[p];
          end
        end
        `QSP_REG_LEVEL:
        begin
          for (int i = 0; i < 4; i++)
          begin
            s_next.rdata[8*i +: 8] = 8'(level[i]);
          end
        end
        `QSP_REG_SCHED:
        begin
          s_next.rdata[1:0] = s_reg.cur;
          s_next.rdata[`QSP_SCHED_CREDIT_LSB +: 8] = s_reg.credit;
          s_next.rdata[`QSP_SCHED_OUT_BIT] = s_reg.out_valid;
          s_next.rdata[`QSP_SCHED_AVAIL_LSB +: 4] = pop_valid;
        end
        `QSP_REG_SENT_LO:
        begin
          s_next.rdata = {s_reg.sent[1], s_reg.sent[0]};
        end
        `QSP_REG_SENT_HI:
        begin
          s_next.rdata = {s_reg.sent[3], s_reg.sent[2]};
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      s_reg <= STATE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA_O = s_reg.rdata;
  assign TX_VALID_O = s_reg.out_valid;
  assign TX_QUEUE_O = s_reg.out_queue;
  assign TX_DATA_O = s_reg.out_data;

endmodule

// *** tb/qsp_sched_properties.sv ***
// Port-level assertions for the QoS scheduler.
`include "qsp_defines.svh"
module qsp_sched_properties #(
  parameter int DATA_W = 16
)(
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [`QSP_ADDR_W-1:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic PKT_VALID_I,
  input wire logic PKT_READY_O,
  input wire logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire qsp_pkg::qsp_queue_t TX_QUEUE_O,
  input wire logic [DATA_W-1:0] TX_DATA_O
);
  logic [31:0] wgt_reg;
  logic [15:0] map_reg;
  logic [1:0] mode_reg;
  logic [6:0] cnt_reg;
  // Shadows of writable settings and of packets held, so readback is judged over time.
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      wgt_reg <= 32'h08040201;
      map_reg <= 16'hfa50;
      mode_reg <= 2'h2;
      cnt_reg <= 7'h0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 7'(PKT_VALID_I && PKT_READY_O) - 7'(TX_VALID_O && TX_READY_I);
      if (REG_WR_I && REG_ADDR_I == `QSP_REG_WEIGHT)
        wgt_reg <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == `QSP_REG_MAP)
        map_reg <= REG_WDATA_I[15:0];
      if (REG_WR_I && REG_ADDR_I == `QSP_REG_CTRL)
        mode_reg <= (REG_WDATA_I[1:0] == 2'h3) ? 2'h2 : REG_WDATA_I[1:0];
    end
  end
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
    else $error("read data outside its cycle");
  a_rd_unmapped: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) > 8'h20
    |-> REG_RDATA_O == 32'h0) else $error("unmapped read not zero");
  a_weight_rd: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 8'h04
    |-> REG_RDATA_O == $past(wgt_reg)) else $error("weight readback wrong");
  a_map_rd: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 8'h08
    |-> REG_RDATA_O[15:0] == $past(map_reg)) else $error("map readback wrong");
  a_mode_rd: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 8'h00
    |-> REG_RDATA_O[1:0] == $past(mode_reg)) else $error("mode readback wrong");
  a_tx_hold: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O
    && $stable(TX_DATA_O) && $stable(TX_QUEUE_O)) else $error("output dropped early");
  a_valid_held: assert property (cnt_reg != 7'h0 && !(TX_VALID_O && TX_READY_I) |=> TX_VALID_O)
    else $error("held packet not offered");
  a_valid_backed: assert property (TX_VALID_O |-> cnt_reg != 7'h0)
    else $error("output valid with no packet held");
  a_ready_empty: assert property (cnt_reg == 7'h0 |-> PKT_READY_O)
    else $error("refused while empty");
endmodule
bind qsp_scheduler qsp_sched_properties #(.DATA_W(DATA_W)) u_props (.*);

// *** tb/qsp_mac_model.sv ***
// Egress MAC model that accepts descriptors and logs them.
module qsp_mac_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic valid_i,
  output logic ready_o,
  input wire qsp_pkg::qsp_queue_t queue_i,
  input wire logic [15:0] data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  qsp_pkg::qsp_queue_t logq[$];
  logic [15:0] logd[$];
  // Slow mode accepts every other cycle so the output register sits stalled.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ready_o <= 1'b0;
    else
    begin
      ready_o <= go_i && !(slow_i && ready_o);
      if (valid_i && ready_o)
      begin
        logq.push_back(queue_i);
        logd.push_back(data_i);
      end
    end
  end
endmodule

// *** tb/qsp_scheduler_tb_top.sv ***
// Self-checking testbench for the QoS scheduler.
`include "qsp_defines.svh"
module qsp_scheduler_tb_top
  import qsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_s, rd_s, pv, tag, go, slow, pready, tvalid, tready;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [2:0] pcp, port;
  logic [15:0] pdata, tdata;
  qsp_queue_t tq;
  qsp_queue_t expq[$];
  logic [31:0] expd[$];
  int err_total, num_checks, seq;
  always #4 clk = ~clk;
  qsp_scheduler uut (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .PKT_VALID_I(pv),
    .PKT_READY_O(pready), .PKT_TAGGED_I(tag), .PKT_PCP_I(pcp), .PKT_PORT_I(port),
    .PKT_DATA_I(pdata), .TX_VALID_O(tvalid), .TX_READY_I(tready), .TX_QUEUE_O(tq),
    .TX_DATA_O(tdata));
  qsp_mac_model mac (
    .clk_i(clk), .rst_i(rst), .go_i(go), .slow_i(slow), .valid_i(tvalid),
    .ready_o(tready), .queue_i(tq), .data_i(tdata));
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic fail(string m);
    err_total++;
    $display("unexpected at %0t ns: %s", $time, m);
  endtask
  task automatic chk32(logic [31:0] g, logic [31:0] e);
    num_checks++;
    if (g !== e)
      fail($sformatf("value %h, want %h", g, e));
  endtask
  task automatic chkq(qsp_queue_t g, qsp_queue_t e);
    num_checks++;
    if (g !== e)
      fail($sformatf("queue %0d, want %0d", g, e));
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    got = rdata;
    chk32(got, e);
    @(posedge clk);
  endtask
  task automatic push(logic t, logic [2:0] p, logic [2:0] po);
    int i;
    pv <= 1'b1;
    tag <= t;
    pcp <= p;
    port <= po;
    pdata <= seq[15:0];
    seq++;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 200);
    if (pready !== 1'b1)
    begin
      fail("ingress stalled");
      report_and_stop();
    end
    @(posedge clk);
    pv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pq(qsp_queue_t q, int n);
    repeat (n) push(1'b1, {q, 1'b0}, 3'h0);
  endtask
  task automatic eq(qsp_queue_t q, int n);
    repeat (n) expq.push_back(q);
  endtask
  task automatic drain(logic s);
    slow <= s;
    go <= 1'b1;
    for (int i = 0; i < 500 && mac.logq.size() < expq.size(); i++)
      @(posedge clk);
    if (mac.logq.size() != expq.size())
    begin
      fail("drain count");
      report_and_stop();
    end
    foreach (expq[k])
      chkq(mac.logq[k], expq[k]);
    foreach (expd[k])
      chk32({16'h0, mac.logd[k]}, expd[k]);
    go <= 1'b0;
    mac.logq.delete();
    mac.logd.delete();
    expq.delete();
    expd.delete();
    @(posedge clk);
  endtask
  task automatic t_regs;
    rdc(`QSP_REG_WEIGHT, 32'h08040201);
    rdc(`QSP_REG_MAP, 32'h0000fa50);
    rdc(`QSP_REG_CTRL, 32'h2);
    rdc(`QSP_REG_PORT_CFG, 32'h0);
    rdc(8'hfc, 32'h0);
    rdc(`QSP_REG_SENT_LO, 32'h0);
    rdc(`QSP_REG_SCHED, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_map;
    wr(`QSP_REG_CTRL, 32'h0);
    for (int p = 0; p < 8; p++)
    begin
      push(1'b1, 3'(p), 3'h0);
      eq(qsp_queue_t'(p / 2), 1);
    end
    drain(1'b0);
    $display("t_map done");
  endtask
  task automatic t_port;
    push(1'b0, 3'h7, 3'h2);
    wr(`QSP_REG_PORT_CMD, 32'h0004000e);
    push(1'b0, 3'h7, 3'h2);
    push(1'b0, 3'h0, 3'h5);
    wr(`QSP_REG_PORT_CMD, 32'h0000000c);
    rdc(`QSP_REG_PORT_CFG, 32'hcccccccc);
    push(1'b0, 3'h0, 3'h5);
    wr(`QSP_REG_MAP, 32'h00003a50);
    push(1'b1, 3'h7, 3'h0);
    push(1'b1, 3'h6, 3'h0);
    eq(0, 1);
    eq(3, 1);
    eq(0, 1);
    eq(2, 1);
    eq(0, 1);
    eq(3, 1);
    drain(1'b1);
    wr(`QSP_REG_MAP, 32'h0000fa50);
    wr(`QSP_REG_PORT_CMD, 32'h0);
    $display("t_port done");
  endtask
  task automatic t_strict;
    wr(`QSP_REG_CTRL, 32'h1);
    pq(0, 2);
    pq(3, 1);
    pq(1, 1);
    pq(3, 1);
    eq(0, 1);
    eq(3, 2);
    eq(1, 1);
    eq(0, 1);
    drain(1'b1);
    $display("t_strict done");
  endtask
  task automatic t_wrr;
    wr(`QSP_REG_CTRL, 32'h3);
    rdc(`QSP_REG_CTRL, 32'h2);
    pq(3, 10);
    pq(2, 4);
    pq(1, 2);
    pq(0, 1);
    eq(3, 8);
    eq(2, 4);
    eq(1, 2);
    eq(0, 1);
    eq(3, 2);
    drain(1'b1);
    wr(`QSP_REG_WEIGHT, 32'h02010101);
    wr(`QSP_REG_CTRL, 32'h2);
    pq(3, 3);
    pq(2, 2);
    eq(3, 2);
    eq(2, 1);
    eq(3, 1);
    eq(2, 1);
    drain(1'b0);
    wr(`QSP_REG_WEIGHT, 32'h08040201);
    $display("t_wrr done");
  endtask
  task automatic t_fill;
    wr(`QSP_REG_CTRL, 32'h0);
    repeat (17)
    begin
      expd.push_back(32'(seq[15:0]));
      pq(0, 1);
      eq(0, 1);
    end
    rdc(`QSP_REG_LEVEL, 32'h10);
    pv <= 1'b1;
    @(negedge clk);
    chk32({31'h0, pready}, 32'h0);
    @(posedge clk);
    pv <= 1'b0;
    drain(1'b1);
    rdc(`QSP_REG_LEVEL, 32'h0);
    $display("t_fill done");
  endtask
  initial
  begin
    {wr_s, rd_s, pv, tag, go, slow} = 6'h0;
    {addr, wdata, pcp, port, pdata} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_map();
    t_port();
    t_strict();
    t_wrr();
    t_fill();
    report_and_stop();
  end
endmodule
